//--- sclkg_regs.vh
// Constants of the system clock generator: register layout and timing.
// Assumes inclusion by the generator modules only.
`ifndef SCLKG_REGS_VH
`define SCLKG_REGS_VH
`define SCLKG_PMR_ADDR      8'h3B
`define SCLKG_PMR_RESET     8'h48
`define SCLKG_PMR_MSTOP_BIT 5
`define SCLKG_PMR_DIV_LSB   6
`define SCLKG_DIV_MIDDLE    2'b01
`define SCLKG_DIV_HIGH      2'b00
`define SCLKG_DIV_LOW       2'b10
`define SCLKG_MID_DIV       4'h8
`define SCLKG_HIGH_DIV      4'h2
`define SCLKG_STAB_DIV      5'h10
`define SCLKG_PRE_LOAD      8'hFF
`define SCLKG_T1_LOAD       8'h01
`define SCLKG_AUTO_SHORT    4'h5
`define SCLKG_AUTO_LONG     4'h7
`endif

//--- sclkg_stab_timer.v
// Stop-release stabilisation timer: prescaler 12 and timer 1 chained.
// Assumes a one-cycle count tick from the oscillator divided by sixteen.
`default_nettype none
`include "sclkg_regs.vh"
module sclkg_stab_timer (
    input  wire       ref_clk_i,
    input  wire       rst_n_i,
    input  wire       load_i,
    input  wire       tick_i,
    input  wire       run_i,
    output reg        uflow_o,
    output reg  [7:0] pre_o,
    output reg  [7:0] t1_o
);
    // Prescaler underflow steps timer 1; timer 1 underflow ends the wait
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_o   <= `SCLKG_PRE_LOAD;
            t1_o    <= `SCLKG_T1_LOAD;
            uflow_o <= 1'b0;
        end else begin
            uflow_o <= 1'b0;
            if (load_i) begin
                pre_o <= `SCLKG_PRE_LOAD; // [R10]
                t1_o  <= `SCLKG_T1_LOAD;  // [R10]
            end else if (run_i && tick_i) begin
                pre_o <= pre_o - 8'h01; // [R12]
                if (pre_o == 8'h00) begin
                    t1_o <= t1_o - 8'h01;
                    if (t1_o == 8'h00)
                        uflow_o <= 1'b1; // [R13]
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- sclkg_core.v
// System clock generator: speed modes, stop and wait states, I2C auto wake.
// Assumes oscillator and I2C line levels arrive synchronous to ref_clk_i,
// and that the CPU writes the mode register through a plain write port.
//
// Notes on behaviour
// [R1] Only main oscillator runs after power-up; sub pins are port pins.
// [R2] Middle speed divides main clock by eight, selected after reset.
// [R3] High speed runs at half the main oscillator frequency.
// [R4] Low speed runs at half the sub oscillator frequency.
// [R5] Software keeps both oscillators stable and main above three times sub.
// [R6] Main clock stop bit five halts main oscillator during low speed.
// [R7] Software waits for main oscillator to settle after restarting it.
// [R8] Sub oscillator needs an external resonator, no external clock.
// [R9] Stop freezes internal clock high and halts both oscillators.
// [R10] Stop entry with select bit zero loads prescaler FF and timer one.
// [R11] Select bit one leaves prescaler and timer untouched on stop entry.
// [R12] During release prescaler counts selected oscillator divided by sixteen.
// [R13] Interrupt restarts oscillator; clock withheld high until timer underflow.
// [R14] Reset exit from stop gives no wait; reset held until stable.
// [R15] Wait freezes clock high; reset or interrupt resumes it at once.
// [R16] Software enables wake interrupts before stop or wait.
// [R17] Software clears timer one interrupt enable before stop.
// [R18] Low speed with auto bit: SCL or SDA edge switches to middle speed.
// [R19] Wait select picks five or seven low-speed cycles before the switch; the code counts five or seven sub oscillator cycles.
// [R20] Bits six and seven of the mode register select the speed.
// [R21] Mode register sits at 3B and resets to 01001000.
// [R22] Sub oscillator pins become oscillator pins when sub enable is set.
`default_nettype none
`include "sclkg_regs.vh"
module sclkg_core (
    input  wire       ref_clk_i,
    input  wire       rst_n_i,
    input  wire       main_osc_in_i,
    input  wire       sub_osc_in_i,
    input  wire       reg_wr_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    input  wire       stop_instruction_i,
    input  wire       wait_instruction_i,
    input  wire       ext_irq_i,
    input  wire       irq_i,
    input  wire       stab_sel_i,
    input  wire       sub_en_i,
    input  wire       auto_sw_en_i,
    input  wire       auto_wait_sel_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output reg  [7:0] pmr_o,
    output reg        phi_o,
    output reg        main_osc_en_o,
    output reg        sub_osc_en_o,
    output reg        sub_pins_osc_o,
    output reg        stopped_o,
    output reg        waiting_o,
    output reg  [7:0] pre_o,
    output reg  [7:0] t1_o
);
    localparam [3:0] ST_RUN  = 4'b0001;
    localparam [3:0] ST_STOP = 4'b0010;
    localparam [3:0] ST_STAB = 4'b0100;
    localparam [3:0] ST_WAIT = 4'b1000;

    reg  [3:0] state_r;
    reg  [3:0] state_nxt;
    reg        main_d_r;
    reg        sub_d_r;
    reg        scl_d_r;
    reg        sda_d_r;
    reg  [2:0] div_cnt_r;
    reg  [3:0] stab_cnt_r;
    reg  [3:0] auto_cnt_r;
    reg        auto_busy_r;
    reg        auto_arm_r;
    reg        phi_nxt;
    reg        tick_nxt;
    wire [1:0] div_sel;
    wire       low_speed;
    wire       main_edge;
    wire       sub_edge;
    wire       sub_fall;
    wire       src_edge;
    wire       line_edge;
    wire       stab_load;
    wire       stab_uflow;
    wire [7:0] pre_w;
    wire [7:0] t1_w;

    assign div_sel   = pmr_o[`SCLKG_PMR_DIV_LSB +: 2];
    assign low_speed = (div_sel == `SCLKG_DIV_LOW);
    assign main_edge = main_osc_in_i & ~main_d_r;
    assign sub_edge  = sub_osc_in_i & ~sub_d_r;
    assign sub_fall  = ~sub_osc_in_i & sub_d_r;
    // Release count source follows the speed currently selected in the mode register
    assign src_edge  = low_speed ? sub_edge : main_edge; // [R12]
    assign line_edge = (scl_i ^ scl_d_r) | (sda_i ^ sda_d_r);
    assign stab_load = (state_r == ST_RUN) && stop_instruction_i && !stab_sel_i; // [R10] [R11]

    // Input edge history
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            main_d_r <= 1'b0;
            sub_d_r  <= 1'b0;
            scl_d_r  <= 1'b1;
            sda_d_r  <= 1'b1;
        end else begin
            main_d_r <= main_osc_in_i;
            sub_d_r  <= sub_osc_in_i;
            scl_d_r  <= scl_i;
            sda_d_r  <= sda_i;
        end
    end

    // Low-power state machine
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (stop_instruction_i)
                    state_nxt = ST_STOP; // [R9]
                else if (wait_instruction_i)
                    state_nxt = ST_WAIT; // [R15]
            end
            ST_STOP: begin
                if (ext_irq_i)
                    state_nxt = ST_STAB; // [R13]
            end
            ST_STAB: begin
                if (stab_uflow)
                    state_nxt = ST_RUN; // [R13]
            end
            ST_WAIT: begin
                if (irq_i || ext_irq_i)
                    state_nxt = ST_RUN; // [R15]
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    // Reset exit from stop jumps straight to run with no wait
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            state_r <= ST_RUN; // [R14]
        else
            state_r <= state_nxt;
    end

    // Mode register, plus auto return to middle speed on I2C activity
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pmr_o       <= `SCLKG_PMR_RESET; // [R21] [R2]
            auto_busy_r <= 1'b0;
            auto_cnt_r  <= 4'h0;
            auto_arm_r  <= 1'b0;
        end else begin
            if (reg_wr_i && (reg_addr_i == `SCLKG_PMR_ADDR))
                pmr_o <= reg_wdata_i; // [R20]
            if (auto_busy_r) begin
                // Counting waits for a falling sub edge, so the wait spans x.5 cycles
                if (sub_fall)
                    auto_arm_r <= 1'b1; // [R19]
                if (auto_arm_r && sub_edge) begin
                    if (auto_cnt_r == 4'h1) begin
                        auto_busy_r <= 1'b0;
                        pmr_o[`SCLKG_PMR_DIV_LSB +: 2] <= `SCLKG_DIV_MIDDLE; // [R18]
                    end
                    auto_cnt_r <= auto_cnt_r - 4'h1;
                end
            end else if (auto_sw_en_i && low_speed && line_edge && state_r == ST_RUN) begin
                // Edge lands mid-cycle, hence the half-cycle spread
                auto_busy_r <= 1'b1;
                auto_arm_r  <= 1'b0;
                auto_cnt_r  <= auto_wait_sel_i ? `SCLKG_AUTO_LONG : `SCLKG_AUTO_SHORT; // [R19]
                pmr_o[`SCLKG_PMR_MSTOP_BIT] <= 1'b0; // [R18]
            end
        end
    end

    // Divide the selected source; half rates toggle on each source edge
    always @* begin
        phi_nxt  = phi_o;
        tick_nxt = 1'b0;
        if (state_r != ST_RUN) begin
            phi_nxt = 1'b1; // [R9] [R13] [R15]
        end else if (div_sel == `SCLKG_DIV_HIGH) begin
            if (main_edge)
                phi_nxt = ~phi_o; // [R3]
        end else if (low_speed) begin
            if (sub_edge)
                phi_nxt = ~phi_o; // [R4]
        end else if (main_edge && div_cnt_r[1:0] == 2'b11) begin
            phi_nxt = ~phi_o; // [R2]
        end
        if (state_r == ST_STAB && src_edge && stab_cnt_r == 4'hF)
            tick_nxt = 1'b1; // [R12]
    end

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phi_o      <= 1'b1;
            div_cnt_r  <= 3'h0;
            stab_cnt_r <= 4'h0;
        end else begin
            phi_o <= phi_nxt;
            if (main_edge)
                div_cnt_r <= div_cnt_r + 3'h1;
            if (state_r != ST_STAB)
                stab_cnt_r <= 4'h0;
            else if (src_edge)
                stab_cnt_r <= stab_cnt_r + 4'h1;
        end
    end

    // Oscillator enables and status; sub stays off until software asks
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            main_osc_en_o  <= 1'b1; // [R1]
            sub_osc_en_o   <= 1'b0; // [R1]
            sub_pins_osc_o <= 1'b0; // [R1]
            stopped_o      <= 1'b0;
            waiting_o      <= 1'b0;
            pre_o          <= `SCLKG_PRE_LOAD;
            t1_o           <= `SCLKG_T1_LOAD;
        end else begin
            main_osc_en_o  <= (state_nxt != ST_STOP) &&
                              !(pmr_o[`SCLKG_PMR_MSTOP_BIT] && low_speed); // [R6] [R9]
            sub_osc_en_o   <= sub_en_i && (state_nxt != ST_STOP); // [R22] [R9]
            sub_pins_osc_o <= sub_en_i; // [R22]
            stopped_o      <= (state_nxt == ST_STOP) || (state_nxt == ST_STAB);
            waiting_o      <= (state_nxt == ST_WAIT);
            pre_o          <= pre_w;
            t1_o           <= t1_w;
        end
    end

    // Tick is a registered one-cycle pulse from the divide-by-sixteen
    reg tick_r;
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            tick_r <= 1'b0;
        else
            tick_r <= tick_nxt;
    end

    sclkg_stab_timer u_timer (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .load_i    (stab_load),
        .tick_i    (tick_r),
        .run_i     (state_r == ST_STAB),
        .uflow_o   (stab_uflow),
        .pre_o     (pre_w),
        .t1_o      (t1_w)
    );
endmodule
`default_nettype wire

//--- sclkg_osc_model.sv
// Resonator model: main and sub oscillator levels seen by the generator.
// Assumes the generator's enables; a halted resonator holds its level.
`default_nettype none
module sclkg_osc_model #(
    parameter int MAIN_HALF = 2,
    parameter int SUB_HALF  = 16
) (
    input  wire logic ref_clk_i,
    input  wire logic main_en_i,
    input  wire logic sub_en_i,
    output var  logic main_o,
    output var  logic sub_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int mc = 0;
    int sc = 0;
    initial main_o = 1'b0;
    initial sub_o = 1'b0;
    // Sub is a resonator only, main kept well above three times sub
    always @(negedge ref_clk_i) begin
        mc = main_en_i ? (mc + 1) % MAIN_HALF : 0;
        sc = sub_en_i ? (sc + 1) % SUB_HALF : 0;
        if (main_en_i && mc == 0) main_o <= ~main_o;
        if (sub_en_i && sc == 0) sub_o <= ~sub_o;
    end
endmodule
`default_nettype wire

//--- sclkg_chk_assertions.sv
// Checker of the clock generator core: reset, stop, wait, auto switch.
// Assumes binding to sclkg_core; sees its ports only.
`default_nettype none
module sclkg_chk (
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       stop_instruction_i,
    input wire logic       wait_instruction_i,
    input wire logic       irq_i,
    input wire logic       sub_en_i,
    input wire logic       auto_sw_en_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic [7:0] pmr_o,
    input wire logic       phi_o,
    input wire logic       main_osc_en_o,
    input wire logic       sub_osc_en_o,
    input wire logic       sub_pins_osc_o,
    input wire logic       stopped_o,
    input wire logic       waiting_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Entry conditions, only honoured from run
    sequence s_stop_enter;
        stop_instruction_i && !stopped_o && !waiting_o;
    endsequence
    sequence s_wait_enter;
        wait_instruction_i && !stopped_o && !waiting_o && !irq_i;
    endsequence
    sequence s_line_edge;
        pmr_o[7:6] == 2'b10 && auto_sw_en_i && ($changed(scl_i) || $changed(sda_i))
            && !stopped_o && !waiting_o;
    endsequence
    a_reset_value: assert property (!$past(rst_n_i) |-> pmr_o == 8'h48 && main_osc_en_o)
        else $error("mode register or main enable wrong after reset");
    a_stop_entry: assert property (s_stop_enter |=> stopped_o && !main_osc_en_o && !sub_osc_en_o)
        else $error("stop entry did not halt both oscillators");
    a_stop_clk_high: assert property (stopped_o && $past(stopped_o) |-> phi_o)
        else $error("internal clock not held high while stopped");
    a_wait_entry: assert property (s_wait_enter |=> waiting_o ##1 phi_o)
        else $error("wait entry did not hold the clock high");
    a_wait_exit: assert property (waiting_o && irq_i |=> !waiting_o)
        else $error("interrupt did not end wait at once");
    a_speed_write: assert property (reg_wr_i && reg_addr_i == 8'h3B && reg_wdata_i[7:6] == 2'b00
        && pmr_o[7:6] != 2'b10 && !stopped_o && !waiting_o |=> pmr_o[7:6] == 2'b00)
        else $error("speed field not written");
    a_main_stop: assert property (pmr_o[7:5] == 3'b101 && !stopped_o
        && !(auto_sw_en_i && ($changed(scl_i) || $changed(sda_i))) |=> !main_osc_en_o)
        else $error("main oscillator running with stop bit in low speed");
    a_sub_pins: assert property (!sub_en_i ##1 !sub_en_i |-> !sub_pins_osc_o && !sub_osc_en_o)
        else $error("sub pins left port use without enable");
    a_auto_switch: assert property (s_line_edge |-> ##[1:2] main_osc_en_o
        ##[1:400] pmr_o[7:6] == 2'b01)
        else $error("line edge did not return to middle speed");
endmodule
bind sclkg_core sclkg_chk u_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .stop_instruction_i(stop_instruction_i),
    .wait_instruction_i(wait_instruction_i), .irq_i(irq_i), .sub_en_i(sub_en_i),
    .auto_sw_en_i(auto_sw_en_i), .scl_i(scl_i), .sda_i(sda_i), .pmr_o(pmr_o), .phi_o(phi_o),
    .main_osc_en_o(main_osc_en_o), .sub_osc_en_o(sub_osc_en_o),
    .sub_pins_osc_o(sub_pins_osc_o), .stopped_o(stopped_o), .waiting_o(waiting_o)
);
`default_nettype wire

//--- tb_system_clock_generator.sv
// Testbench of the clock generator core: speeds, stop, wait, auto switch.
// Assumes the resonator model and the bound checker are compiled with it.
`default_nettype none
module tb_system_clock_generator;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, stop_instruction = 1'b0, wt = 1'b0;
    logic       ext = 1'b0, irq = 1'b0, ssel = 1'b0, sen = 1'b0, auto = 1'b0, asel = 1'b0;
    logic       scl = 1'b1, sda = 1'b1, mosc, sosc, phi, men, soen, spins, stopped, waiting;
    logic [7:0] addr = 8'h00, wdata = 8'h00, pmr, pre, t1;
    int         bad_count = 0;
    int         check_count = 0;
    sclkg_core DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .main_osc_in_i(mosc), .sub_osc_in_i(sosc),
        .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .stop_instruction_i(stop_instruction),
        .wait_instruction_i(wt), .ext_irq_i(ext), .irq_i(irq), .stab_sel_i(ssel), .sub_en_i(sen),
        .auto_sw_en_i(auto), .auto_wait_sel_i(asel), .scl_i(scl), .sda_i(sda), .pmr_o(pmr),
        .phi_o(phi), .main_osc_en_o(men), .sub_osc_en_o(soen), .sub_pins_osc_o(spins),
        .stopped_o(stopped), .waiting_o(waiting), .pre_o(pre), .t1_o(t1));
    sclkg_osc_model u_osc (.ref_clk_i(clk), .main_en_i(men), .sub_en_i(soen), .main_o(mosc),
        .sub_o(sosc));
    // 200 MHz reference
    always #2.5 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // A wait that used its bound ends the run
    task automatic limit(input int n, input int lim);
        if (n >= lim) begin
            bad_count++;
            $display("Error wait expected done seen timeout");
            finish_test();
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
    endtask
    // Phi rising edges in 256 cycles, one edge of slack for phase
    task automatic rate_is(input int e);
        int n;
        logic p;
        n = 0;
        p = phi;
        repeat (256) begin
            cyc(1);
            if (phi && !p) n++;
            p = phi;
        end
        chk("phi rate", 8'(e), (n >= e - 1 && n <= e + 1) ? 8'(e) : 8'(n));
    endtask
    task automatic t_reset();
        chk("mode reg", 8'h48, pmr);
        chk("main en", 8'h01, men);
        chk("sub pins", 8'h00, spins);
        rate_is(8);
        $display("reset test done");
    endtask
    task automatic t_speed();
        wreg(8'h3B, 8'h00);
        cyc(40);
        rate_is(32);
        wreg(8'h3A, 8'h40);
        chk("foreign write", 8'h00, pmr);
        sen = 1'b1;
        cyc(100);
        chk("sub pins", 8'h01, spins);
        wreg(8'h3B, 8'h80);
        cyc(80);
        rate_is(4);
        wreg(8'h3B, 8'hA0);
        cyc(2);
        chk("main en", 8'h00, men);
        $display("speed test done");
    endtask
    // First pass wakes on SCL with the short wait, second on SDA with the long
    task automatic t_auto();
        int n;
        for (int s = 0; s < 2; s++) begin
            asel = s[0];
            wreg(8'h3B, 8'hA0);
            auto = 1'b1;
            cyc(40);
            if (s == 0)
                scl = ~scl;
            else
                sda = ~sda;
            for (n = 0; n < 400 && pmr[7:6] != 2'b01; n++) cyc(1);
            limit(n, 400);
            chk("main en", 8'h01, men);
            chk("switch delay", 8'h01, n > 140 + 64 * s && n < 181 + 64 * s);
            auto = 1'b0;
            cyc(40);
        end
        $display("auto test done");
    endtask
    task automatic t_stop();
        int n;
        logic hi;
        logic [7:0] p, t;
        stop_instruction = 1'b1;
        cyc(1);
        stop_instruction = 1'b0;
        cyc(2);
        chk("stopped", 8'h04, {stopped, men, soen});
        ext = 1'b1;
        cyc(2);
        ext = 1'b0;
        hi = 1'b1;
        for (n = 0; n < 40000 && stopped; n++) begin
            hi = hi & phi;
            cyc(1);
        end
        limit(n, 40000);
        chk("held high", 8'h01, hi);
        chk("release time", 8'h01, n > 31900 && n < 33500);
        ssel = 1'b1;
        p = pre;
        t = t1;
        stop_instruction = 1'b1;
        cyc(1);
        stop_instruction = 1'b0;
        cyc(3);
        chk("prescaler kept", p, pre);
        chk("timer kept", t, t1);
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(2);
        chk("reset exit", 8'h01, {stopped, men});
        $display("stop test done");
    endtask
    task automatic t_wait();
        logic hi;
        wt = 1'b1;
        cyc(1);
        wt = 1'b0;
        cyc(2);
        hi = 1'b1;
        repeat (30) begin
            hi = hi & phi & waiting;
            cyc(1);
        end
        chk("wait held", 8'h01, hi);
        irq = 1'b1;
        cyc(2);
        irq = 1'b0;
        chk("wait exit", 8'h00, waiting);
        rate_is(8);
        $display("wait test done");
    endtask
    initial begin
        cyc(5);
        rst_n = 1'b1;
        cyc(2);
        t_reset();
        t_speed();
        t_auto();
        t_stop();
        t_wait();
        finish_test();
    end
endmodule
`default_nettype wire
